/* icg_defines.svh */
// Constants for the image calibration gradient search controller
`ifndef ICG_DEFINES_SVH
`define ICG_DEFINES_SVH

`define ICG_GW 5
`define ICG_PW 8
`define ICG_TW 8
`define ICG_TRIM_MIN (-15)
`define ICG_TRIM_MAX 15
`define ICG_STEP 1
`define ICG_SUB_MAX 5
`define ICG_ITER_MAX 50
`define ICG_SIG_RATIO 4
`define ICG_TEMP_DELTA_C 20
`define ICG_CLK_PERIOD_NS 4
`define ICG_SETTLE_NS 1000
`define ICG_SETTLE_CYC ((`ICG_SETTLE_NS + `ICG_CLK_PERIOD_NS - 1) / `ICG_CLK_PERIOD_NS)
`define ICG_POWER_INIT 8'hff

`endif

/* icg_pkg.sv */
// Types shared by the gradient search controller
`include "icg_defines.svh"

package icg_pkg;

  typedef enum logic [2:0] {
    ICG_OP_WR_TRIM = 3'h0,
    ICG_OP_RD_RSSI = 3'h1,
    ICG_OP_SET_TX = 3'h2,
    ICG_OP_SET_RX = 3'h3,
    ICG_OP_ADC_EN = 3'h4,
    ICG_OP_RD_TEMP = 3'h5
  } icg_op_t;

  typedef struct packed {
    icg_op_t op;
    logic signed [`ICG_GW-1:0] gain;
    logic signed [`ICG_GW-1:0] phase;
  } icg_cmd_t;

  typedef struct packed {
    logic signed [`ICG_GW-1:0] gain;
    logic signed [`ICG_GW-1:0] phase;
    logic [`ICG_PW-1:0] power;
  } icg_result_t;

  typedef enum logic [3:0] {
    ICG_S_IDLE = 4'h0,
    ICG_S_TX = 4'h1,
    ICG_S_ADC = 4'h2,
    ICG_S_TEMP = 4'h3,
    ICG_S_TWAIT = 4'h4,
    ICG_S_RX = 4'h5,
    ICG_S_WRITE = 4'h6,
    ICG_S_SETTLE = 4'h7,
    ICG_S_READ = 4'h8,
    ICG_S_WAIT = 4'h9,
    ICG_S_STEP = 4'ha,
    ICG_S_FINAL = 4'hb
  } icg_state_t;

endpackage

/* icg_search.sv */
// Gradient descent image calibration controller driving a transceiver
//
// What this block does
// R01 - Search starts at the supplied gain and phase pair as first centre.
// R02 - Each centre probes gain one unit above and measures image power there.
// R03 - Gain gradient equals centre power minus gain-probe power.
// R04 - Each centre probes phase one unit above and measures image power there.
// R05 - Phase gradient equals centre power minus phase-probe power.
// R06 - Positive gain gradient steps gain up one; negative steps it down one.
// R07 - Gain holds when its gradient is far smaller than the phase gradient.
// R08 - Phase follows the same step and hold logic against gain.
// R09 - Next centre differs from current by at most one unit per axis.
// R10 - Keep lowest centre power and its position as the best record.
// R11 - Centre not lower than best increments the suboptimal counter.
// R12 - Suboptimal counter reaching five stops; best is the optimum.
// R13 - Iteration counter exceeding fifty stops with the best record.
// R14 - Flag recalibration when temperature moved twenty degrees since last calibration.
// R15 - Put transceiver in transmit mode before reading the temperature.
// R16 - Set the converter enable bit before reading the temperature.
// R17 - Clamp every written gain and phase, probes included, to the trim range.
// R18 - Wait for settling after each trim write before reading signal strength.
`timescale 1ns/1ps
`include "icg_defines.svh"

module icg_search #(
  parameter logic signed [`ICG_GW-1:0] TRIM_MIN = `ICG_TRIM_MIN,
  parameter logic signed [`ICG_GW-1:0] TRIM_MAX = `ICG_TRIM_MAX,
  parameter int unsigned SUB_MAX = `ICG_SUB_MAX,
  parameter int unsigned ITER_MAX = `ICG_ITER_MAX,
  parameter int unsigned SIG_RATIO = `ICG_SIG_RATIO,
  parameter int unsigned TEMP_LSB_PER_C = 1
) (
  input wire logic clk_sys_i, // 250 MHz
  input wire logic rst_i, // Sync, active high
  input wire logic start_i, // Pulse: run a calibration
  input wire logic temp_check_i, // Pulse: compare temperature
  input wire logic signed [`ICG_GW-1:0] init_gain_i, // Start gain
  input wire logic signed [`ICG_GW-1:0] init_phase_i, // Start phase
  output icg_pkg::icg_cmd_t cmd_o, // Command to transceiver
  output logic cmd_valid_o, // Command valid
  input wire logic cmd_ready_i, // Command taken
  input wire logic rsp_valid_i, // Readback valid
  input wire logic [`ICG_PW-1:0] rsp_data_i, // Readback value
  output logic busy_o, // Sequence running
  output logic done_o, // Pulse: search finished
  output icg_pkg::icg_result_t best_o, // Best point found
  output logic recal_o // Temperature drift flag
);
  import icg_pkg::*;

  localparam int PWX = `ICG_PW + 4;
  localparam logic [15:0] SETTLE_CYC = 16'(`ICG_SETTLE_CYC);
  localparam logic [`ICG_TW:0] TEMP_DELTA = (`ICG_TW+1)'(`ICG_TEMP_DELTA_C * TEMP_LSB_PER_C);
  localparam logic [7:0] SUB_LIM = 8'(SUB_MAX);
  localparam logic [7:0] ITER_LIM = 8'(ITER_MAX);

  // ------------------------------------------------------------
  // Parameter checks
  // ------------------------------------------------------------
  if (TRIM_MIN >= TRIM_MAX) begin : g_bad_range
    $error("Trim range is empty");
  end
  if (SUB_MAX < 1 || SUB_MAX > 255 || ITER_MAX < 1 || ITER_MAX > 254) begin : g_bad_limits
    $error("Counter limits out of range");
  end
  if (SIG_RATIO < 1 || SIG_RATIO > 15) begin : g_bad_ratio
    $error("Significance ratio out of range");
  end

  typedef struct packed {
    icg_state_t state;
    logic [1:0] pt;
    logic cal_mode;
    logic signed [`ICG_GW-1:0] c_gain;
    logic signed [`ICG_GW-1:0] c_phase;
    logic [`ICG_PW-1:0] pow_a;
    logic [`ICG_PW-1:0] pow_b;
    logic [`ICG_PW-1:0] pow_c;
    logic [7:0] sub;
    logic [7:0] iter;
    logic [15:0] settle;
    logic [`ICG_TW-1:0] temp_ref;
    logic ref_valid;
    logic tx_on;
    logic adc_on;
    icg_cmd_t cmd;
    logic cmd_valid;
    logic busy;
    logic done;
    icg_result_t best;
    logic recal;
  } icg_regs_t;

  icg_regs_t q, d;

  function automatic logic signed [`ICG_GW-1:0] clamp(input logic signed [`ICG_GW:0] v);
    if (v > TRIM_MAX) begin
      clamp = TRIM_MAX;
    end else if (v < TRIM_MIN) begin
      clamp = TRIM_MIN;
    end else begin
      clamp = v[`ICG_GW-1:0];
    end
  endfunction

  function automatic logic signed [`ICG_GW-1:0] step(input logic signed [`ICG_GW-1:0] c,
                                                    input logic signed [`ICG_PW:0] grad, input logic hold);
    logic signed [`ICG_GW:0] w;
    w = {c[`ICG_GW-1], c};
    if (hold || grad == '0) begin
      step = c;
    end else if (grad > 0) begin
      step = clamp(w + (`ICG_GW+1)'(`ICG_STEP));
    end else begin
      step = clamp(w - (`ICG_GW+1)'(`ICG_STEP));
    end
  endfunction

  function automatic logic [`ICG_PW:0] mag(input logic signed [`ICG_PW:0] v);
    mag = v[`ICG_PW] ? (`ICG_PW+1)'(-v) : v;
  endfunction

  // ------------------------------------------------------------
  // Gradients and probe points
  // ------------------------------------------------------------
  logic signed [`ICG_PW:0] grad_g, grad_p;
  logic [PWX-1:0] mg_scaled, mp_scaled;
  logic hold_g, hold_p;
  logic signed [`ICG_GW-1:0] probe_gain, probe_phase;
  logic [`ICG_TW:0] temp_diff;

  assign grad_g = $signed({1'b0, q.pow_a}) - $signed({1'b0, q.pow_b}); // R03
  assign grad_p = $signed({1'b0, q.pow_a}) - $signed({1'b0, q.pow_c}); // R05
  assign mg_scaled = PWX'(mag(grad_g)) * PWX'(SIG_RATIO);
  assign mp_scaled = PWX'(mag(grad_p)) * PWX'(SIG_RATIO);
  // Small against the other axis means scaled magnitude still below it
  assign hold_g = mg_scaled < PWX'(mag(grad_p)); // R07
  assign hold_p = mp_scaled < PWX'(mag(grad_g)); // R08
  assign probe_gain = clamp({q.c_gain[`ICG_GW-1], q.c_gain} + (`ICG_GW+1)'(`ICG_STEP)); // R02 R17
  assign probe_phase = clamp({q.c_phase[`ICG_GW-1], q.c_phase} + (`ICG_GW+1)'(`ICG_STEP)); // R04 R17
  assign temp_diff = (rsp_data_i >= q.temp_ref) ? (`ICG_TW+1)'(rsp_data_i - q.temp_ref)
                                                : (`ICG_TW+1)'(q.temp_ref - rsp_data_i);

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    d = q;
    d.done = 1'b0;
    unique case (q.state)
      ICG_S_IDLE: begin
        if (start_i) begin
          d.c_gain = clamp({init_gain_i[`ICG_GW-1], init_gain_i}); // R01
          d.c_phase = clamp({init_phase_i[`ICG_GW-1], init_phase_i}); // R01
          d.best.power = `ICG_POWER_INIT;
          d.sub = '0;
          d.iter = '0;
          d.recal = 1'b0;
          d.cal_mode = 1'b1;
          d.busy = 1'b1;
          d.state = ICG_S_TX;
        end else if (temp_check_i) begin
          // Counters left by the last search must not look like a runaway search
          d.sub = '0;
          d.iter = '0;
          d.cal_mode = 1'b0;
          d.busy = 1'b1;
          d.state = ICG_S_TX;
        end
      end
      ICG_S_TX: begin
        if (!q.cmd_valid) begin
          d.cmd_valid = 1'b1;
          d.cmd.op = ICG_OP_SET_TX;
        end else if (cmd_ready_i) begin
          d.cmd_valid = 1'b0;
          d.tx_on = 1'b1;
          d.state = ICG_S_ADC;
        end
      end
      ICG_S_ADC: begin
        // Sets converter_enable_bit on the transceiver
        if (!q.cmd_valid) begin
          d.cmd_valid = 1'b1;
          d.cmd.op = ICG_OP_ADC_EN;
        end else if (cmd_ready_i) begin
          d.cmd_valid = 1'b0;
          d.adc_on = 1'b1;
          d.state = ICG_S_TEMP;
        end
      end
      ICG_S_TEMP: begin
        if (!q.cmd_valid) begin
          d.cmd_valid = 1'b1;
          d.cmd.op = ICG_OP_RD_TEMP; // R15 R16
        end else if (cmd_ready_i) begin
          d.cmd_valid = 1'b0;
          d.state = ICG_S_TWAIT;
        end
      end
      ICG_S_TWAIT: begin
        if (rsp_valid_i) begin
          if (q.cal_mode) begin
            // Reference taken at the calibration itself
            d.temp_ref = rsp_data_i[`ICG_TW-1:0];
            d.ref_valid = 1'b1;
          end else if (q.ref_valid && temp_diff >= TEMP_DELTA) begin
            d.recal = 1'b1; // R14
          end
          d.state = ICG_S_RX;
        end
      end
      ICG_S_RX: begin
        if (!q.cmd_valid) begin
          d.cmd_valid = 1'b1;
          d.cmd.op = ICG_OP_SET_RX;
        end else if (cmd_ready_i) begin
          d.cmd_valid = 1'b0;
          d.tx_on = 1'b0;
          d.pt = 2'h0;
          d.state = q.cal_mode ? ICG_S_WRITE : ICG_S_IDLE;
          d.busy = q.cal_mode;
        end
      end
      ICG_S_WRITE: begin
        if (!q.cmd_valid) begin
          d.cmd_valid = 1'b1;
          d.cmd.op = ICG_OP_WR_TRIM;
          d.cmd.gain = (q.pt == 2'h1) ? probe_gain : q.c_gain; // R02
          d.cmd.phase = (q.pt == 2'h2) ? probe_phase : q.c_phase; // R04
        end else if (cmd_ready_i) begin
          d.cmd_valid = 1'b0;
          d.settle = SETTLE_CYC;
          d.state = ICG_S_SETTLE;
        end
      end
      ICG_S_SETTLE: begin
        // Readback right after a trim change shows the old setting
        d.settle = q.settle - 16'h0001; // R18
        if (q.settle <= 16'h0001) begin
          d.state = ICG_S_READ;
        end
      end
      ICG_S_READ: begin
        if (!q.cmd_valid) begin
          d.cmd_valid = 1'b1;
          d.cmd.op = ICG_OP_RD_RSSI; // R18
        end else if (cmd_ready_i) begin
          d.cmd_valid = 1'b0;
          d.state = ICG_S_WAIT;
        end
      end
      ICG_S_WAIT: begin
        if (rsp_valid_i) begin
          unique case (q.pt)
            2'h0: begin
              d.pow_a = rsp_data_i;
              d.iter = q.iter + 8'h01; // R13
              if (rsp_data_i < q.best.power) begin
                d.best.power = rsp_data_i; // R10
                d.best.gain = q.c_gain;
                d.best.phase = q.c_phase;
              end else begin
                d.sub = q.sub + 8'h01; // R11
              end
              if ((rsp_data_i >= q.best.power && q.sub + 8'h01 >= SUB_LIM) || q.iter + 8'h01 > ITER_LIM) begin
                d.state = ICG_S_FINAL; // R12 R13
              end else begin
                d.pt = 2'h1;
                d.state = ICG_S_WRITE;
              end
            end
            2'h1: begin
              d.pow_b = rsp_data_i;
              d.pt = 2'h2;
              d.state = ICG_S_WRITE;
            end
            default: begin
              d.pow_c = rsp_data_i;
              d.state = ICG_S_STEP;
            end
          endcase
        end
      end
      ICG_S_STEP: begin
        d.c_gain = step(q.c_gain, grad_g, hold_g); // R06 R07 R09
        d.c_phase = step(q.c_phase, grad_p, hold_p); // R08 R09
        d.pt = 2'h0;
        d.state = ICG_S_WRITE;
      end
      ICG_S_FINAL: begin
        // Leave the device trimmed at the best point
        if (!q.cmd_valid) begin
          d.cmd_valid = 1'b1;
          d.cmd.op = ICG_OP_WR_TRIM;
          d.cmd.gain = q.best.gain;
          d.cmd.phase = q.best.phase;
        end else if (cmd_ready_i) begin
          d.cmd_valid = 1'b0;
          d.busy = 1'b0;
          d.done = 1'b1;
          d.state = ICG_S_IDLE;
        end
      end
      default: begin
        d.state = ICG_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      q <= '0;
      q.state <= ICG_S_IDLE;
      q.best.power <= `ICG_POWER_INIT;
    end else begin
      q <= d;
    end
  end

  assign cmd_o = q.cmd;
  assign cmd_valid_o = q.cmd_valid;
  assign busy_o = q.busy;
  assign done_o = q.done;
  assign best_o = q.best;
  assign recal_o = q.recal;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [15:0] since_trim;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      since_trim <= '0;
    end else if (q.cmd_valid && cmd_ready_i && q.cmd.op == ICG_OP_WR_TRIM) begin
      since_trim <= '0;
    end else if (since_trim != 16'hffff) begin
      since_trim <= since_trim + 16'h0001;
    end
  end

  property p_gain_probe;
    @(posedge clk_sys_i) disable iff (rst_i)
      (q.state == ICG_S_WRITE && q.pt == 2'h1 && !q.cmd_valid) |=> (cmd_o.gain == $past(probe_gain));
  endproperty
  a_gain_probe: assert property (p_gain_probe) else $error("Gain probe point wrong"); // R02

  property p_phase_probe;
    @(posedge clk_sys_i) disable iff (rst_i)
      (q.state == ICG_S_WRITE && q.pt == 2'h2 && !q.cmd_valid) |=> (cmd_o.phase == $past(probe_phase)
                                                                  && cmd_o.gain == $past(q.c_gain));
  endproperty
  a_phase_probe: assert property (p_phase_probe) else $error("Phase probe point wrong"); // R04

  property p_trim_range;
    @(posedge clk_sys_i) disable iff (rst_i)
      (cmd_valid_o && cmd_o.op == ICG_OP_WR_TRIM) |-> (cmd_o.gain >= TRIM_MIN && cmd_o.gain <= TRIM_MAX
                                                      && cmd_o.phase >= TRIM_MIN && cmd_o.phase <= TRIM_MAX);
  endproperty
  a_trim_range: assert property (p_trim_range) else $error("Trim write out of range"); // R17

  property p_settle;
    @(posedge clk_sys_i) disable iff (rst_i)
      $rose(cmd_valid_o) && cmd_o.op == ICG_OP_RD_RSSI |-> since_trim >= SETTLE_CYC;
  endproperty
  a_settle: assert property (p_settle) else $error("Strength read before settling"); // R18

  property p_neighbour;
    @(posedge clk_sys_i) disable iff (rst_i)
      (q.state == ICG_S_STEP) |=> (q.c_gain - $past(q.c_gain) inside {-1, 0, 1})
                                  && (q.c_phase - $past(q.c_phase) inside {-1, 0, 1});
  endproperty
  a_neighbour: assert property (p_neighbour) else $error("Centre moved more than one unit"); // R09

  property p_best;
    @(posedge clk_sys_i) disable iff (rst_i)
      (q.state == ICG_S_WAIT && q.pt == 2'h0 && rsp_valid_i && rsp_data_i < q.best.power)
        |=> best_o.power == $past(rsp_data_i) && best_o.gain == $past(q.c_gain);
  endproperty
  a_best: assert property (p_best) else $error("Best record not replaced"); // R10

  property p_subopt;
    @(posedge clk_sys_i) disable iff (rst_i)
      (q.state == ICG_S_WAIT && q.pt == 2'h0 && rsp_valid_i && rsp_data_i >= q.best.power)
        |=> q.sub == $past(q.sub) + 8'h01 && $stable(best_o);
  endproperty
  a_subopt: assert property (p_subopt) else $error("Suboptimal count missed"); // R11

  property p_sub_stop;
    @(posedge clk_sys_i) disable iff (rst_i)
      (busy_o && q.sub >= SUB_LIM) |-> q.state == ICG_S_FINAL;
  endproperty
  a_sub_stop: assert property (p_sub_stop) else $error("Search kept going past suboptimal limit"); // R12

  property p_iter_limit;
    @(posedge clk_sys_i) disable iff (rst_i)
      (q.iter > ITER_LIM) |-> (q.state == ICG_S_FINAL || !busy_o);
  endproperty
  a_iter_limit: assert property (p_iter_limit) else $error("Search ran past iteration limit"); // R13

  property p_temp_prep;
    @(posedge clk_sys_i) disable iff (rst_i)
      (cmd_valid_o && cmd_o.op == ICG_OP_RD_TEMP) |-> q.tx_on && q.adc_on;
  endproperty
  a_temp_prep: assert property (p_temp_prep) else $error("Temperature read without transmit and converter"); // R15 R16

endmodule

/* icg_xcvr_model.sv */
// Behavioural transceiver facing the gradient search controller
`timescale 1ns/1ps
`include "icg_defines.svh"

module icg_xcvr_model (
  input wire logic clk_sys_i, // Clock
  input wire logic rst_i, // Sync reset
  input wire icg_pkg::icg_cmd_t cmd_i, // Command
  input wire logic cmd_valid_i, // Command valid
  output logic cmd_ready_o, // Command taken
  output logic rsp_valid_o, // Readback pulse
  output logic [`ICG_PW-1:0] rsp_data_o, // Readback value
  input wire logic [`ICG_TW-1:0] temp_i, // Die temperature code
  input wire logic signed [`ICG_GW-1:0] opt_gain_i, // Surface minimum gain
  input wire logic signed [`ICG_GW-1:0] opt_phase_i, // Surface minimum phase
  output logic viol_o, // Sticky protocol fault
  output int n_rssi_o, // Strength reads seen
  output logic signed [`ICG_GW-1:0] trim_gain_o, // Last trim gain
  output logic signed [`ICG_GW-1:0] trim_phase_o // Last trim phase
);
  import icg_pkg::*;
  logic tx_q, adc_q, pend_q;
  logic [`ICG_PW-1:0] pdata_q;
  int settle_q, lat_q;

  // Steep phase slope, so the gain hold case really occurs
  function automatic logic [`ICG_PW-1:0] surf(logic signed [`ICG_GW-1:0] g, logic signed [`ICG_GW-1:0] p);
    int dg, dp;
    dg = int'(g) - int'(opt_gain_i);
    dp = int'(p) - int'(opt_phase_i);
    dg = dg < 0 ? -dg : dg;
    dp = dp < 0 ? -dp : dp;
    return 8'(dg + 5 * dp + 4);
  endfunction

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      cmd_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_data_o <= 8'h00;
      {tx_q, adc_q, pend_q, viol_o} <= 4'h0;
      n_rssi_o <= 0;
      settle_q <= 0;
      lat_q <= 0;
      trim_gain_o <= 5'h00;
      trim_phase_o <= 5'h00;
    end else begin
      settle_q <= settle_q + 1;
      rsp_valid_o <= 1'b0;
      // Released line keeps moving so a stale sample cannot match
      rsp_data_o <= rsp_data_o + 8'h35;
      if (pend_q) begin
        lat_q <= lat_q - 1;
        if (lat_q <= 1) begin
          rsp_valid_o <= 1'b1;
          rsp_data_o <= pdata_q;
          pend_q <= 1'b0;
        end
      end
      if (cmd_valid_i && cmd_ready_o) begin
        cmd_ready_o <= 1'b0;
        case (cmd_i.op)
          ICG_OP_WR_TRIM: begin
            if (cmd_i.gain < `ICG_TRIM_MIN || cmd_i.gain > `ICG_TRIM_MAX) viol_o <= 1'b1;
            if (cmd_i.phase < `ICG_TRIM_MIN || cmd_i.phase > `ICG_TRIM_MAX) viol_o <= 1'b1;
            trim_gain_o <= cmd_i.gain;
            trim_phase_o <= cmd_i.phase;
            settle_q <= 0;
          end
          ICG_OP_RD_RSSI: begin
            if (settle_q < `ICG_SETTLE_CYC - 1) viol_o <= 1'b1;
            n_rssi_o <= n_rssi_o + 1;
            pend_q <= 1'b1;
            pdata_q <= surf(trim_gain_o, trim_phase_o);
            lat_q <= $urandom_range(1, 6);
          end
          ICG_OP_SET_TX: tx_q <= 1'b1;
          ICG_OP_SET_RX: tx_q <= 1'b0;
          ICG_OP_ADC_EN: adc_q <= 1'b1;
          ICG_OP_RD_TEMP: begin
            if (!tx_q || !adc_q) viol_o <= 1'b1;
            pend_q <= 1'b1;
            pdata_q <= temp_i;
            lat_q <= $urandom_range(1, 6);
          end
          default: viol_o <= 1'b1;
        endcase
      end else if (cmd_valid_i && !pend_q) begin
        // Random stalls give both prompt and slow accepts
        cmd_ready_o <= ($urandom_range(0, 3) == 0);
      end
    end
  end
endmodule

/* test_image_cal_gradient_search.sv */
// Self-checking bench for the gradient search controller
`timescale 1ns/1ps
`include "icg_defines.svh"

module test_image_cal_gradient_search;
  import icg_pkg::*;
  localparam int ITER_LIM = 12;
  logic clk_sys_i, rst_i, start_i, temp_check_i, cmd_valid_o, cmd_ready_i, rsp_valid_i;
  logic busy_o, done_o, recal_o, viol;
  logic signed [`ICG_GW-1:0] init_gain_i, init_phase_i, opt_g, opt_p, trim_g, trim_p;
  logic [`ICG_PW-1:0] rsp_data_i;
  logic [`ICG_TW-1:0] temp_i;
  icg_cmd_t cmd_o;
  icg_result_t best_o;
  int n_rssi, n_errors, tests_run;

  // Short iteration limit keeps the run brief
  icg_search #(.ITER_MAX(ITER_LIM)) DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .start_i(start_i),
    .temp_check_i(temp_check_i), .init_gain_i(init_gain_i), .init_phase_i(init_phase_i), .cmd_o(cmd_o),
    .cmd_valid_o(cmd_valid_o), .cmd_ready_i(cmd_ready_i), .rsp_valid_i(rsp_valid_i), .rsp_data_i(rsp_data_i),
    .busy_o(busy_o), .done_o(done_o), .best_o(best_o), .recal_o(recal_o));

  icg_xcvr_model XCVR (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cmd_i(cmd_o), .cmd_valid_i(cmd_valid_o),
    .cmd_ready_o(cmd_ready_i), .rsp_valid_o(rsp_valid_i), .rsp_data_o(rsp_data_i), .temp_i(temp_i),
    .opt_gain_i(opt_g), .opt_phase_i(opt_p), .viol_o(viol), .n_rssi_o(n_rssi), .trim_gain_o(trim_g),
    .trim_phase_o(trim_p));

  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  function automatic int clampv(int v);
    return (v < `ICG_TRIM_MIN) ? `ICG_TRIM_MIN : (v > `ICG_TRIM_MAX) ? `ICG_TRIM_MAX : v;
  endfunction
  function automatic int absv(int v);
    return v < 0 ? -v : v;
  endfunction
  function automatic int pw(int g, int p);
    return absv(g - int'(opt_g)) + 5 * absv(p - int'(opt_p)) + 4;
  endfunction
  function automatic int stepc(int c, int d, int o);
    if (absv(d) * `ICG_SIG_RATIO < absv(o)) return c;
    return clampv(c + int'(d > 0) - int'(d < 0));
  endfunction
  function automatic int rnd();
    return int'($urandom_range(30)) - 15;
  endfunction

  // ----------------------------------------
  // Checks and handshakes
  // ----------------------------------------
  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic tally_and_finish;
    $display("Counts: %0d checks, %0d mismatches", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic pulse(input bit cal);
    @(posedge clk_sys_i);
    if (cal) start_i <= 1'b1;
    else temp_check_i <= 1'b1;
    @(posedge clk_sys_i);
    start_i <= 1'b0;
    temp_check_i <= 1'b0;
  endtask

  task automatic wait_for(input bit want_done);
    for (int i = 0; i < 40000; i++) begin
      @(posedge clk_sys_i);
      #1;
      if (want_done ? done_o === 1'b1 : busy_o === 1'b0) return;
    end
    chk(1'b0, "wait limit reached");
    tally_and_finish;
  endtask

  task automatic run_cal(input int g0, input int p0, input int og, input int op, input string name);
    int g, p, ng, best, bg, bp, sub, it, nr, pa, pb, pc, r0;
    @(posedge clk_sys_i);
    opt_g <= 5'(og);
    opt_p <= 5'(op);
    init_gain_i <= 5'(g0);
    init_phase_i <= 5'(p0);
    r0 = n_rssi;
    pulse(1'b1);
    g = clampv(g0);
    p = clampv(p0);
    best = 255;
    bg = g;
    bp = p;
    sub = 0;
    it = 0;
    nr = 0;
    forever begin
      pa = pw(g, p);
      nr++;
      it++;
      if (pa < best) {best, bg, bp} = {pa, g, p};
      else sub++;
      if (sub >= `ICG_SUB_MAX || it > ITER_LIM) break;
      pb = pw(clampv(g + 1), p);
      pc = pw(g, clampv(p + 1));
      nr += 2;
      ng = stepc(g, pa - pb, pa - pc);
      p = stepc(p, pa - pc, pa - pb);
      g = ng;
    end
    wait_for(1'b1);
    chk(best_o.gain === 5'(bg) && best_o.phase === 5'(bp), "best position");
    chk(best_o.power === 8'(best), "best power");
    chk(n_rssi - r0 == nr, "strength read count");
    chk(trim_g === best_o.gain && trim_p === best_o.phase, "final trim");
    chk(viol === 1'b0, "device protocol");
    chk(recal_o === 1'b0, "drift flag after calibration");
    $display("Test %s done, %0d points", name, nr);
  endtask

  task automatic temp_chk(input logic [`ICG_TW-1:0] t, input logic expect_flag, input string name);
    @(posedge clk_sys_i);
    temp_i <= t;
    pulse(1'b0);
    wait_for(1'b0);
    chk(recal_o === expect_flag, "drift flag");
    chk(viol === 1'b0, "sensor read order");
    $display("Test %s done", name);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    rst_i = 1'b1;
    {start_i, temp_check_i} = 2'h0;
    {init_gain_i, init_phase_i, opt_g, opt_p} = 20'h00000;
    temp_i = 8'h28;
    n_errors = 0;
    tests_run = 0;
    void'($urandom(32'h0d92));
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    #1;
    chk(best_o.power === `ICG_POWER_INIT && cmd_valid_o === 1'b0 && busy_o === 1'b0, "reset values");
    $display("Test reset done");
    for (int k = 0; k < 3; k++) run_cal(rnd(), rnd(), rnd(), rnd(), "random surface");
    run_cal(-15, 15, 15, -15, "iteration limit");
    run_cal(14, 14, 15, 15, "trim edge");
    temp_chk(8'h3b, 1'b0, "drift 19");
    temp_chk(8'h14, 1'b1, "drift 20");
    temp_chk(8'h28, 1'b1, "drift sticky");
    run_cal(rnd(), rnd(), rnd(), rnd(), "drift clear");
    tally_and_finish;
  end
endmodule
